/* File: src/cascade_counter_cfg.svh */
// offsets, field positions and reset values of the cascadable counter
`ifndef CASCADE_COUNTER_CFG_SVH
`define CASCADE_COUNTER_CFG_SVH

`define CNT_WIDTH_DEFAULT 8
`define CNT_ADDR_W 4
`define CNT_REG_STATUS 4'h0
`define CNT_REG_PRESET 4'h4
`define CNT_REG_CMD 4'h8
`define CNT_CMD_LOAD_BIT 0
`define CNT_ST_TOP_BIT 8
`define CNT_ST_BOTTOM_BIT 9
`define CNT_ST_TC_BIT 10
`define CNT_RESP_OKAY 2'h0
`define CNT_RESP_SLVERR 2'h2
`define CNT_DATA_ZERO 32'h0000_0000

`endif

/* File: src/cascade_counter_pkg.sv */
// types of the cascadable counter
package cascade_counter_pkg;

    // counting style of the block
    typedef enum logic [1:0] {
        CNT_UP_ONLY = 2'b00,
        CNT_UP_DOWN_DIR = 2'b01,
        CNT_SPLIT_ENABLE = 2'b11
    } count_mode_t;

endpackage : cascade_counter_pkg

/* File: src/cascadable_binary_counter.sv */
// configurable cascadable binary counter with an AXI4-Lite register slave
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "cascade_counter_cfg.svh"

// Operation
// - four or eight bits, synchronous rising edge
// - async wipe zeroes count and terminal count
// - sync wipe zeroes count, bottom flag high
// - preset strobe loads value, ignores enables
// - single enable: count up, else hold
// - direction low decrements, high increments
// - up-only terminal count when all ones
// - terminal count follows direction and extreme
// - carry out is terminal count and enable
// - split enables: up increments, down decrements
// - both enables low: hold, carries low
// - top all ones, bottom all zeros
// - carries are flag AND matching enable
// - reset starts zero, top low, bottom high
module cascadable_binary_counter #(
    parameter int WIDTH = `CNT_WIDTH_DEFAULT,
    parameter cascade_counter_pkg::count_mode_t MODE = cascade_counter_pkg::CNT_SPLIT_ENABLE,
    parameter bit ASYNC_CLEAR = 1'b1,
    parameter bit HAS_PRESET = 1'b1
) (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RST_IN,
    // clear and reset of the counter
    input wire logic ASYNC_WIPE_IN,
    input wire logic SYNC_WIPE_IN,
    // parallel load
    input wire logic PRESET_STROBE_IN,
    input wire logic [WIDTH-1:0] PRESET_VALUE_IN,
    // count control
    input wire logic COUNT_ENABLE_IN,
    input wire logic DIRECTION_UP_IN,
    input wire logic UP_STEP_ENABLE_IN,
    input wire logic DOWN_STEP_ENABLE_IN,
    // count and cascade outputs
    output logic [WIDTH-1:0] COUNT_VALUE_OUT,
    output logic TERMINAL_COUNT_OUT,
    output logic ENABLE_CARRY_OUT,
    output logic TOP_FLAG_OUT,
    output logic BOTTOM_FLAG_OUT,
    output logic UP_CARRY_OUT,
    output logic DOWN_CARRY_OUT,
    // axi4-lite write address
    input wire logic [`CNT_ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    // axi4-lite write data
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // axi4-lite write response
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // axi4-lite read address
    input wire logic [`CNT_ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    // axi4-lite read data
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);

    // refuse widths and mode codes the logic cannot serve
    if (WIDTH != 4 && WIDTH != 8) begin : g_bad_width
        $error("counter width must be 4 or 8");
    end
    if (MODE != cascade_counter_pkg::CNT_UP_ONLY && MODE != cascade_counter_pkg::CNT_UP_DOWN_DIR
            && MODE != cascade_counter_pkg::CNT_SPLIT_ENABLE) begin : g_bad_mode
        $error("counter mode code is not defined");
    end

    function automatic logic all_ones(input logic [WIDTH-1:0] v);
        return &v;
    endfunction : all_ones

    function automatic logic all_zeros(input logic [WIDTH-1:0] v);
        return ~|v;
    endfunction : all_zeros

    // write targets that software may change
    function automatic logic reg_writable(input logic [`CNT_ADDR_W-1:0] a);
        return a == `CNT_REG_PRESET || a == `CNT_REG_CMD;
    endfunction : reg_writable

    localparam bit SPLIT = (MODE == cascade_counter_pkg::CNT_SPLIT_ENABLE);
    localparam bit DIRCTL = (MODE == cascade_counter_pkg::CNT_UP_DOWN_DIR);

    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;
    logic [WIDTH-1:0] sw_preset;
    logic sw_load;
    logic clear_async;
    logic wipe_sync;
    logic load;
    logic step_up;
    logic step_down;

    // wipe input meaningful only in the variant that has it
    assign clear_async = ASYNC_CLEAR ? ASYNC_WIPE_IN : 1'b0;
    assign wipe_sync = ASYNC_CLEAR ? 1'b0 : SYNC_WIPE_IN;
    assign load = HAS_PRESET && (PRESET_STROBE_IN || sw_load);

    // enable decode per counting style
    always_comb begin
        if (SPLIT) begin
            // simultaneous enables resolve to increment
            step_up = UP_STEP_ENABLE_IN;
            step_down = DOWN_STEP_ENABLE_IN && !UP_STEP_ENABLE_IN;
        end else if (DIRCTL) begin
            step_up = COUNT_ENABLE_IN && DIRECTION_UP_IN;
            step_down = COUNT_ENABLE_IN && !DIRECTION_UP_IN;
        end else begin
            step_up = COUNT_ENABLE_IN;
            step_down = 1'b0;
        end
    end

    always_comb begin
        if (wipe_sync) begin
            next_count = '0;
        end else if (load) begin
            next_count = HAS_PRESET && sw_load && !PRESET_STROBE_IN ? sw_preset
                : PRESET_VALUE_IN;
        end else if (step_up) begin
            next_count = count + WIDTH'(1);
        end else if (step_down) begin
            next_count = count - WIDTH'(1);
        end else begin
            next_count = count;
        end
    end

    // count register, all bits on one edge
    always_ff @(posedge CLK_IN or posedge RST_IN or posedge clear_async) begin
        if (RST_IN) begin
            count <= '0;
        end else if (clear_async) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    // registered copy of the count on the output pins
    always_ff @(posedge CLK_IN or posedge RST_IN or posedge clear_async) begin
        if (RST_IN || clear_async) begin
            COUNT_VALUE_OUT <= '0;
        end else begin
            COUNT_VALUE_OUT <= next_count;
        end
    end

    // flags taken from next_count so they never lag the count
    always_ff @(posedge CLK_IN or posedge RST_IN or posedge clear_async) begin
        if (RST_IN || clear_async) begin
            TOP_FLAG_OUT <= 1'b0;
        end else begin
            TOP_FLAG_OUT <= all_ones(next_count);
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN or posedge clear_async) begin
        if (RST_IN || clear_async) begin
            BOTTOM_FLAG_OUT <= 1'b1;
        end else begin
            BOTTOM_FLAG_OUT <= all_zeros(next_count);
        end
    end

    // cascade outputs follow enables with no clock delay
    always_comb begin
        TERMINAL_COUNT_OUT = 1'b0;
        ENABLE_CARRY_OUT = 1'b0;
        UP_CARRY_OUT = 1'b0;
        DOWN_CARRY_OUT = 1'b0;
        if (SPLIT) begin
            UP_CARRY_OUT = TOP_FLAG_OUT && UP_STEP_ENABLE_IN;
            DOWN_CARRY_OUT = BOTTOM_FLAG_OUT && DOWN_STEP_ENABLE_IN;
        end else begin
            if (DIRCTL) begin
                TERMINAL_COUNT_OUT = (TOP_FLAG_OUT && DIRECTION_UP_IN)
                    || (BOTTOM_FLAG_OUT && !DIRECTION_UP_IN);
            end else begin
                TERMINAL_COUNT_OUT = TOP_FLAG_OUT;
            end
            if (clear_async) begin
                TERMINAL_COUNT_OUT = 1'b0;
            end
            ENABLE_CARRY_OUT = TERMINAL_COUNT_OUT && COUNT_ENABLE_IN;
        end
    end

    // register bus: write side
    logic aw_held;
    logic w_held;
    logic [`CNT_ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;

    // a second write waits until the first response has drained
    assign do_write = aw_held && w_held && !S_AXI_BVALID;

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            aw_held <= 1'b0;
            S_AXI_AWREADY <= 1'b1;
        end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_held <= 1'b1;
            S_AXI_AWREADY <= 1'b0;
        end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            aw_held <= 1'b0;
            S_AXI_AWREADY <= 1'b1;
        end
    end

    // address kept until the response drains
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            aw_addr <= '0;
        end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_addr <= S_AXI_AWADDR;
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            w_held <= 1'b0;
            S_AXI_WREADY <= 1'b1;
        end else if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_held <= 1'b1;
            S_AXI_WREADY <= 1'b0;
        end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            w_held <= 1'b0;
            S_AXI_WREADY <= 1'b1;
        end
    end

    // data and strobes kept until the response drains
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            w_data <= `CNT_DATA_ZERO;
            w_strb <= 4'h0;
        end else if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
        end
    end

    // write response once both halves are held
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `CNT_RESP_OKAY;
        end else if (do_write) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= reg_writable(aw_addr) ? `CNT_RESP_OKAY
                : `CNT_RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    // software load pulse, one cycle after the command write
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            sw_load <= 1'b0;
        end else begin
            sw_load <= do_write && aw_addr == `CNT_REG_CMD && w_strb[0]
                && w_data[`CNT_CMD_LOAD_BIT];
        end
    end

    // preset register
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            sw_preset <= '0;
        end else if (do_write && aw_addr == `CNT_REG_PRESET && w_strb[0]) begin
            sw_preset <= w_data[WIDTH-1:0];
        end
    end

    // register bus: read side
    logic [31:0] status_word;

    // status word: count, top, bottom, terminal count
    always_comb begin
        status_word = `CNT_DATA_ZERO;
        status_word[WIDTH-1:0] = count;
        status_word[`CNT_ST_TOP_BIT] = TOP_FLAG_OUT;
        status_word[`CNT_ST_BOTTOM_BIT] = BOTTOM_FLAG_OUT;
        status_word[`CNT_ST_TC_BIT] = TERMINAL_COUNT_OUT;
    end

    // read answer one cycle after the address
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= `CNT_DATA_ZERO;
            S_AXI_RRESP <= `CNT_RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP <= `CNT_RESP_OKAY;
            unique case (S_AXI_ARADDR)
                `CNT_REG_STATUS: begin
                    S_AXI_RDATA <= status_word;
                end
                `CNT_REG_PRESET: begin
                    S_AXI_RDATA <= {{(32-WIDTH){1'b0}}, sw_preset};
                end
                `CNT_REG_CMD: begin
                    S_AXI_RDATA <= `CNT_DATA_ZERO;
                end
                default: begin
                    S_AXI_RDATA <= `CNT_DATA_ZERO;
                    S_AXI_RRESP <= `CNT_RESP_SLVERR;
                end
            endcase
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end
    end

endmodule : cascadable_binary_counter

/* File: src/cascade_counter_pkg_dummy_unused.sv */
// holds no logic: the whole counter sits in cascadable_binary_counter.sv

/* File: testbench/cascade_counter_properties.sv */
// port assertions of the cascadable counter
`timescale 1ns/10ps
module cascade_counter_properties #(
    parameter int WIDTH = 8,
    parameter cascade_counter_pkg::count_mode_t MODE = cascade_counter_pkg::CNT_SPLIT_ENABLE,
    parameter bit ASYNC_CLEAR = 1'b1
) (
    // clock, reset and counter inputs
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic ASYNC_WIPE_IN,
    input wire logic SYNC_WIPE_IN,
    input wire logic PRESET_STROBE_IN,
    input wire logic [WIDTH-1:0] PRESET_VALUE_IN,
    input wire logic UP_STEP_ENABLE_IN,
    input wire logic DOWN_STEP_ENABLE_IN,
    // counter outputs and bus readiness
    input wire logic [WIDTH-1:0] COUNT_VALUE_OUT,
    input wire logic TOP_FLAG_OUT,
    input wire logic BOTTOM_FLAG_OUT,
    input wire logic UP_CARRY_OUT,
    input wire logic DOWN_CARRY_OUT,
    input wire logic S_AXI_AWREADY
);
    localparam bit SPLIT = (MODE == cascade_counter_pkg::CNT_SPLIT_ENABLE);
    logic [2:0] quiet;
    logic free;
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) quiet <= 3'h0;
        else if (!S_AXI_AWREADY) quiet <= 3'h0;
        else if (quiet != 3'h7) quiet <= quiet + 3'h1;
    end
    // no software load pending, no wipe, no pin load
    assign free = (quiet > 3'h4) && !ASYNC_WIPE_IN && !PRESET_STROBE_IN
        && (ASYNC_CLEAR || !SYNC_WIPE_IN);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    a_up_carry_and: assert property (
        UP_CARRY_OUT == (TOP_FLAG_OUT && UP_STEP_ENABLE_IN)) else $error("up carry wrong");
    a_down_carry_and: assert property (
        DOWN_CARRY_OUT == (BOTTOM_FLAG_OUT && DOWN_STEP_ENABLE_IN)) else $error("down carry wrong");
    a_top_all_ones: assert property (
        TOP_FLAG_OUT == (&COUNT_VALUE_OUT)) else $error("top flag wrong");
    a_bottom_all_zero: assert property (
        BOTTOM_FLAG_OUT == !(|COUNT_VALUE_OUT)) else $error("bottom flag wrong");
    a_wipe_clears: assert property (
        ASYNC_CLEAR && ASYNC_WIPE_IN |-> COUNT_VALUE_OUT == '0 && BOTTOM_FLAG_OUT && !TOP_FLAG_OUT)
        else $error("wipe did not clear");
    a_preset_loads: assert property (
        PRESET_STROBE_IN && !ASYNC_WIPE_IN && (ASYNC_CLEAR || !SYNC_WIPE_IN) ##1 !ASYNC_WIPE_IN
        |-> COUNT_VALUE_OUT == $past(PRESET_VALUE_IN)) else $error("preset not loaded");
    a_up_step_inc: assert property (
        free && UP_STEP_ENABLE_IN ##1 !ASYNC_WIPE_IN
        |-> COUNT_VALUE_OUT == $past(COUNT_VALUE_OUT) + 1'b1) else $error("no increment");
    a_down_step_dec: assert property (
        free && DOWN_STEP_ENABLE_IN && !UP_STEP_ENABLE_IN ##1 !ASYNC_WIPE_IN
        |-> COUNT_VALUE_OUT == $past(COUNT_VALUE_OUT) - 1'b1) else $error("no decrement");
    a_idle_holds: assert property (
        SPLIT && free && !UP_STEP_ENABLE_IN && !DOWN_STEP_ENABLE_IN
        |-> !UP_CARRY_OUT && !DOWN_CARRY_OUT
        ##1 (ASYNC_WIPE_IN || $stable(COUNT_VALUE_OUT))) else $error("idle not held");
endmodule : cascade_counter_properties

bind cascadable_binary_counter cascade_counter_properties #(.WIDTH(WIDTH), .MODE(MODE),
    .ASYNC_CLEAR(ASYNC_CLEAR)) props_inst (.*);

/* File: testbench/step_driver.sv */
// user logic that drives the split count enables
`timescale 1ns/10ps
module step_driver (
    // requests of the user side
    input wire logic want_up_in,
    input wire logic want_down_in,
    // enables toward the counter
    output logic up_step_out,
    output logic down_step_out
);
    assign up_step_out = want_up_in;
    // up wins, so both enables never rise together
    assign down_step_out = want_down_in && !want_up_in;
endmodule : step_driver

/* File: testbench/tb_top.sv */
// self-checking bench of the cascadable counter
`timescale 1ns/10ps
`include "cascade_counter_cfg.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_top;
    localparam int W = 8;
    logic CLK_IN = 1'b0, RST_IN = 1'b1, ASYNC_WIPE_IN = 1'b0, SYNC_WIPE_IN = 1'b0;
    logic PRESET_STROBE_IN = 1'b0, COUNT_ENABLE_IN = 1'b0, DIRECTION_UP_IN = 1'b0;
    logic want_up = 1'b0, want_down = 1'b0, S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0;
    logic S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
    logic [W-1:0] PRESET_VALUE_IN = '0;
    logic [3:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0, S_AXI_WSTRB = '0;
    logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA, rd, r;
    logic [W-1:0] COUNT_VALUE_OUT, exp_cnt, cur;
    logic TERMINAL_COUNT_OUT, ENABLE_CARRY_OUT, TOP_FLAG_OUT, BOTTOM_FLAG_OUT, UP_CARRY_OUT;
    logic DOWN_CARRY_OUT, UP_STEP_ENABLE_IN, DOWN_STEP_ENABLE_IN, S_AXI_AWREADY, S_AXI_WREADY;
    logic S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rs;
    int failures = 0, checks = 0, cycles = 0;
    wire [31:0] obs = {21'h0, TERMINAL_COUNT_OUT, BOTTOM_FLAG_OUT, TOP_FLAG_OUT, COUNT_VALUE_OUT};
    cascadable_binary_counter #(.WIDTH(W)) cascadable_binary_counter_inst (.*);
    step_driver step_driver_inst (.want_up_in(want_up), .want_down_in(want_down),
        .up_step_out(UP_STEP_ENABLE_IN), .down_step_out(DOWN_STEP_ENABLE_IN));
    wire [W-1:0] s_cnt [2];
    wire [1:0] s_tc, s_ceo, s_top, s_bot;
    logic [W-1:0] s_exp [2], hi, sc;
    // stage 0: direction pin, sync wipe; stage 1: up only, async clear
    for (genvar k = 0; k < 2; k++) begin : side_stage
        cascadable_binary_counter #(.WIDTH(W), .ASYNC_CLEAR(k == 1),
            .MODE(k == 0 ? cascade_counter_pkg::CNT_UP_DOWN_DIR
                : cascade_counter_pkg::CNT_UP_ONLY)) cascadable_binary_counter_inst (
            .CLK_IN(CLK_IN), .RST_IN(RST_IN), .ASYNC_WIPE_IN(k == 1 && ASYNC_WIPE_IN),
            .SYNC_WIPE_IN(k == 0 && SYNC_WIPE_IN), .PRESET_STROBE_IN(PRESET_STROBE_IN),
            .PRESET_VALUE_IN(PRESET_VALUE_IN), .COUNT_ENABLE_IN(COUNT_ENABLE_IN),
            .DIRECTION_UP_IN(DIRECTION_UP_IN), .UP_STEP_ENABLE_IN(1'b0),
            .DOWN_STEP_ENABLE_IN(1'b0), .COUNT_VALUE_OUT(s_cnt[k]),
            .TERMINAL_COUNT_OUT(s_tc[k]), .ENABLE_CARRY_OUT(s_ceo[k]), .TOP_FLAG_OUT(s_top[k]),
            .BOTTOM_FLAG_OUT(s_bot[k]), .UP_CARRY_OUT(), .DOWN_CARRY_OUT(),
            .S_AXI_AWADDR(4'h0), .S_AXI_AWVALID(1'b0), .S_AXI_AWREADY(),
            .S_AXI_WDATA(32'h0000_0000), .S_AXI_WSTRB(4'h0), .S_AXI_WVALID(1'b0),
            .S_AXI_WREADY(), .S_AXI_BRESP(), .S_AXI_BVALID(), .S_AXI_BREADY(1'b0),
            .S_AXI_ARADDR(4'h0), .S_AXI_ARVALID(1'b0), .S_AXI_ARREADY(), .S_AXI_RDATA(),
            .S_AXI_RRESP(), .S_AXI_RVALID(), .S_AXI_RREADY(1'b0));
    end
    always #25 CLK_IN = ~CLK_IN;
    task automatic results();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    always @(posedge CLK_IN) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            results();
        end
    end
    function automatic logic [W-1:0] nxt(input logic [W-1:0] c, input logic wipe, ld,
            input logic [W-1:0] v, input logic up, dn);
        if (wipe) return '0;
        if (ld) return v;
        if (up) return c + 1'b1;
        if (dn) return c - 1'b1;
        return c;
    endfunction : nxt
    function automatic logic [31:0] status(input logic [W-1:0] c);
        return {21'h0, 1'b0, ~|c, &c, c};
    endfunction : status
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge CLK_IN);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_WSTRB <= 4'hF;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        do begin
            @(posedge CLK_IN);
            if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
        end while (S_AXI_BVALID !== 1'b1);
        rs = S_AXI_BRESP;
        S_AXI_BREADY <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [3:0] a);
        @(posedge CLK_IN);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        do begin
            @(posedge CLK_IN);
            if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
        end while (S_AXI_RVALID !== 1'b1);
        rd = S_AXI_RDATA;
        rs = S_AXI_RRESP;
        S_AXI_RREADY <= 1'b0;
    endtask : axi_rd
    initial begin
        void'($urandom(13722));
        repeat (4) @(posedge CLK_IN);
        RST_IN <= 1'b0;
        @(negedge CLK_IN);
        `CHK("reset status", status('0), obs)
        axi_wr(`CNT_REG_PRESET, 32'h0000_00FF);
        axi_wr(`CNT_REG_CMD, 32'h0000_0001);
        `CHK("cmd resp", `CNT_RESP_OKAY, rs)
        repeat (4) @(posedge CLK_IN);
        axi_rd(`CNT_REG_STATUS);
        `CHK("status after load", status('1), rd)
        axi_rd(4'hC);
        `CHK("unmapped read", {`CNT_DATA_ZERO, `CNT_RESP_SLVERR}, {rd, rs})
        axi_wr(`CNT_REG_STATUS, 32'h0000_0000);
        `CHK("status write resp", `CNT_RESP_SLVERR, rs)
        @(posedge CLK_IN);
        RST_IN <= 1'b1;
        @(posedge CLK_IN);
        RST_IN <= 1'b0;
        @(negedge CLK_IN);
        `CHK("status after reset", status('0), obs)
        exp_cnt = '0;
        s_exp[0] = '0;
        s_exp[1] = '0;
        hi = '0;
        repeat (400) begin
            @(posedge CLK_IN);
            exp_cnt = nxt(exp_cnt, ASYNC_WIPE_IN, PRESET_STROBE_IN, PRESET_VALUE_IN,
                UP_STEP_ENABLE_IN, DOWN_STEP_ENABLE_IN);
            s_exp[0] = nxt(s_exp[0], SYNC_WIPE_IN, PRESET_STROBE_IN, PRESET_VALUE_IN,
                COUNT_ENABLE_IN && DIRECTION_UP_IN, COUNT_ENABLE_IN && !DIRECTION_UP_IN);
            s_exp[1] = nxt(s_exp[1], ASYNC_WIPE_IN, PRESET_STROBE_IN, PRESET_VALUE_IN,
                COUNT_ENABLE_IN, 1'b0);
            // next stage of a chain, fed by this stage's carries
            hi = nxt(hi, ASYNC_WIPE_IN, PRESET_STROBE_IN, PRESET_VALUE_IN, UP_CARRY_OUT,
                DOWN_CARRY_OUT);
            r = $urandom;
            ASYNC_WIPE_IN <= (r[4:0] == 5'h0);
            PRESET_STROBE_IN <= (r[7:5] == 3'h0);
            // corner presets of all ones or all zeros half the time, else a random byte
            PRESET_VALUE_IN <= r[8] ? {W{r[9]}} : r[23:16];
            want_up <= r[10];
            want_down <= r[11];
            SYNC_WIPE_IN <= (r[15:12] == 4'h0);
            COUNT_ENABLE_IN <= r[13];
            DIRECTION_UP_IN <= r[14];
            @(negedge CLK_IN);
            cur = ASYNC_WIPE_IN ? '0 : exp_cnt;
            `CHK("count", cur, COUNT_VALUE_OUT)
            `CHK("flags", status(cur), obs)
            `CHK("up carry", &cur & UP_STEP_ENABLE_IN, UP_CARRY_OUT)
            `CHK("down carry", ~|cur & DOWN_STEP_ENABLE_IN, DOWN_CARRY_OUT)
            `CHK("chain top", &{hi, cur}, TOP_FLAG_OUT & (&hi))
            sc = s_exp[0];
            `CHK("dir count", sc, s_cnt[0])
            `CHK("dir flags", {~|sc, &sc}, {s_bot[0], s_top[0]})
            `CHK("dir terminal", DIRECTION_UP_IN ? &sc : ~|sc, s_tc[0])
            `CHK("dir carry", (DIRECTION_UP_IN ? &sc : ~|sc) & COUNT_ENABLE_IN, s_ceo[0])
            sc = ASYNC_WIPE_IN ? '0 : s_exp[1];
            `CHK("up count", sc, s_cnt[1])
            `CHK("up terminal", {&sc, &sc & COUNT_ENABLE_IN}, {s_tc[1], s_ceo[1]})
        end
        results();
    end
endmodule : tb_top
